// *** core/tcd_pkg.sv ***
// Package for the telescope command host: opcodes, fields, counts, types.
// Assumes one 20 MHz clock and a byte-wide serialiser outside this block.
package tcd_pkg;

  // ----------------------------------------------------------------
  // Opcodes and patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_GET_ID = 8'h14;
  localparam logic [7:0] OP_RESET_LINK = 8'h12;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h11;
  localparam logic [7:0] OP_READ_CLEAR_IRQ = 8'h70;
  localparam logic [7:0] OP_FE_STATUS = 8'h94;
  localparam logic [7:0] OP_READ_TIMER = 8'hD1;
  localparam logic [7:0] OP_READ_DATING = 8'hD8;
  localparam logic [7:0] OP_HOUSEKEEPING = 8'h40;
  localparam logic [7:0] OP_STOP = 8'h68;
  localparam logic [7:0] OP_TEST_GEN = 8'hE0;
  localparam logic [7:0] OP_SET_TIMER = 8'hD0;
  // Upper bits of patterns carrying a field in the low bits: bits 1:0, or bits 3:0 for PF_LATCHUP
  localparam logic [5:0] PF_FILTER = 6'h0C;
  localparam logic [5:0] PF_SINGLE = 6'h12;
  localparam logic [5:0] PF_LINEAR = 6'h2D;
  localparam logic [5:0] PF_LOG = 6'h2C;
  localparam logic [5:0] PF_START = 6'h18;
  localparam logic [5:0] PF_POWER = 6'h20;
  localparam logic [5:0] PF_CONTROL = 6'h23;
  localparam logic [5:0] PF_ENABLE = 6'h22;
  localparam logic [5:0] PF_DRIVE = 6'h21;
  localparam logic [5:0] PF_INIT_LIN = 6'h2A;
  localparam logic [5:0] PF_FE_CONFIG = 6'h24;
  localparam logic [5:0] PF_MODE_PAGE = 6'h28;
  localparam logic [3:0] PF_LATCHUP = 4'hF;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int LOG_BINS = 32;
  localparam int BIN_BYTES = 3;
  localparam int TIMER_BYTES = 3;
  localparam int CONFIG_BYTES = 3;
  localparam logic [7:0] TEL_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    TCD_GET_ID, TCD_RESET_LINK, TCD_RESET_DEVICE, TCD_READ_CLEAR_IRQ,
    TCD_FE_STATUS, TCD_READ_TIMER, TCD_READ_DATING, TCD_HOUSEKEEPING,
    TCD_FILTER, TCD_SINGLE, TCD_LINEAR, TCD_LOG, TCD_START, TCD_STOP,
    TCD_POWER, TCD_CONTROL, TCD_ENABLE, TCD_DRIVE, TCD_INIT_LIN,
    TCD_FE_CONFIG, TCD_MODE_PAGE, TCD_TEST_GEN, TCD_SET_TIMER,
    TCD_LATCHUP
  } tcd_cmd_t;

  // User order: command, 2-bit field, up to three argument bytes
  typedef struct packed {
    tcd_cmd_t cmd;
    logic [1:0] field;
    logic [23:0] args;
  } tcd_req_t;

  typedef struct packed {
    logic [7:0] data;
  } tcd_byte_t;

endpackage

// *** core/tcd_host.sv ***
// Host-side command encoder for the telescope control device.
// Turns user orders into an opcode byte and its argument bytes, sent
// over a byte-wide link; answer bytes pass back through a 2-entry buffer.
`timescale 1ns/1ps

module tcd_host #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // User order
  input wire logic req_valid,
  output logic req_ready,
  input wire tcd_pkg::tcd_req_t req,
  // Link, bytes towards the device
  output logic tx_valid,
  input wire logic tx_ready,
  output tcd_pkg::tcd_byte_t tx_byte,
  // Link, answer bytes from the device
  input wire logic rx_valid,
  output logic rx_ready,
  input wire tcd_pkg::tcd_byte_t rx_byte,
  // Answer bytes to the user
  output logic ans_valid,
  input wire logic ans_ready,
  output tcd_pkg::tcd_byte_t ans_byte,
  // Status
  output logic busy
);

  // ----------------------------------------------------------------
  // Opcode and argument count
  // ----------------------------------------------------------------
  function automatic logic [7:0] opcode(tcd_pkg::tcd_cmd_t c,
                                        logic [1:0] f,
                                        logic [7:0] a0);
    logic [7:0] o;
    o = tcd_pkg::OP_GET_ID;
    case (c)
      tcd_pkg::TCD_GET_ID: o = tcd_pkg::OP_GET_ID;
      tcd_pkg::TCD_RESET_LINK: o = tcd_pkg::OP_RESET_LINK;
      tcd_pkg::TCD_RESET_DEVICE: o = tcd_pkg::OP_RESET_DEVICE;
      tcd_pkg::TCD_READ_CLEAR_IRQ: o = tcd_pkg::OP_READ_CLEAR_IRQ;
      tcd_pkg::TCD_FE_STATUS: o = tcd_pkg::OP_FE_STATUS;
      tcd_pkg::TCD_READ_TIMER: o = tcd_pkg::OP_READ_TIMER;
      tcd_pkg::TCD_READ_DATING: o = tcd_pkg::OP_READ_DATING;
      tcd_pkg::TCD_HOUSEKEEPING: o = tcd_pkg::OP_HOUSEKEEPING;
      tcd_pkg::TCD_FILTER: o = {tcd_pkg::PF_FILTER, f};
      tcd_pkg::TCD_SINGLE: o = {tcd_pkg::PF_SINGLE, f};
      tcd_pkg::TCD_LINEAR: o = {tcd_pkg::PF_LINEAR, f};
      tcd_pkg::TCD_LOG: o = {tcd_pkg::PF_LOG, f};
      tcd_pkg::TCD_START: o = {tcd_pkg::PF_START, f};
      tcd_pkg::TCD_STOP: o = tcd_pkg::OP_STOP;
      tcd_pkg::TCD_POWER: o = {tcd_pkg::PF_POWER, f};
      tcd_pkg::TCD_CONTROL: o = {tcd_pkg::PF_CONTROL, f};
      tcd_pkg::TCD_ENABLE: o = {tcd_pkg::PF_ENABLE, f};
      tcd_pkg::TCD_DRIVE: o = {tcd_pkg::PF_DRIVE, f};
      tcd_pkg::TCD_INIT_LIN: o = {tcd_pkg::PF_INIT_LIN, f};
      tcd_pkg::TCD_FE_CONFIG: o = {tcd_pkg::PF_FE_CONFIG, f};
      tcd_pkg::TCD_MODE_PAGE: o = {tcd_pkg::PF_MODE_PAGE, f};
      tcd_pkg::TCD_TEST_GEN: o = tcd_pkg::OP_TEST_GEN;
      tcd_pkg::TCD_SET_TIMER: o = tcd_pkg::OP_SET_TIMER;
      // Low nibble of this opcode carries settings taken from args
      tcd_pkg::TCD_LATCHUP: o = {tcd_pkg::PF_LATCHUP, a0[3:0]};
      default: o = tcd_pkg::OP_GET_ID;
    endcase
    return o;
  endfunction

  function automatic logic [1:0] arg_count(tcd_pkg::tcd_cmd_t c);
    logic [1:0] n;
    n = 2'h0;
    case (c)
      tcd_pkg::TCD_FE_CONFIG: n = 2'(tcd_pkg::CONFIG_BYTES);
      tcd_pkg::TCD_SET_TIMER: n = 2'(tcd_pkg::TIMER_BYTES);
      tcd_pkg::TCD_MODE_PAGE: n = 2'h1;
      tcd_pkg::TCD_TEST_GEN: n = 2'h1;
      tcd_pkg::TCD_LATCHUP: n = 2'h1;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TCD_IDLE, TCD_OPC, TCD_ARG} tcd_state_t;

  tcd_state_t state_q;
  logic [7:0] byte_q;
  logic [23:0] args_q;
  logic [1:0] left_q;
  logic tx_fire;

  assign tx_fire = tx_valid && tx_ready;
  assign req_ready = (state_q == TCD_IDLE);
  assign tx_valid = (state_q != TCD_IDLE);
  assign busy = (state_q != TCD_IDLE);

  // Byte is registered so the link sees no mux glitch while it waits
  // for ready; costs one flop rank, no latency.
  assign tx_byte.data = byte_q;

  // Arguments leave most significant byte first; the full count is
  // always sent so the device never runs a half-loaded command.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= TCD_IDLE;
      byte_q <= 8'h00;
      args_q <= 24'h000000;
      left_q <= 2'h0;
    end else begin
      case (state_q)
        TCD_IDLE: begin
          if (req_valid) begin
            byte_q <= opcode(req.cmd, req.field, req.args[23:16]);
            left_q <= arg_count(req.cmd);
            // Left-align so the first argument is always in the top byte
            case (arg_count(req.cmd))
              2'h1: args_q <= {req.args[7:0], 16'h0000};
              2'h2: args_q <= {req.args[15:0], 8'h00};
              default: args_q <= req.args;
            endcase
            state_q <= TCD_OPC;
          end
        end
        TCD_OPC: begin
          if (tx_fire) begin
            byte_q <= args_q[23:16];
            state_q <= (left_q == 2'h0) ? TCD_IDLE : TCD_ARG;
          end
        end
        TCD_ARG: begin
          if (tx_fire) begin
            byte_q <= args_q[15:8];
            args_q <= {args_q[15:0], 8'h00};
            left_q <= left_q - 2'h1;
            if (left_q == 2'h1) begin
              state_q <= TCD_IDLE;
            end
          end
        end
        default: state_q <= TCD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer buffer
  // ----------------------------------------------------------------
  // Two entries let the receiver stall without dropping a byte.
  logic [7:0] mem_q [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH)-1:0] wr_q, rd_q;
  logic [$clog2(BUF_DEPTH):0] cnt_q;
  logic push, pop;
  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(BUF_DEPTH);
  localparam logic [PTR_W:0] ONE_CNT = (PTR_W+1)'(1);

  assign rx_ready = (cnt_q != FULL_CNT);
  assign ans_valid = (cnt_q != '0);
  assign push = rx_valid && rx_ready;
  assign pop = ans_valid && ans_ready;
  assign ans_byte.data = mem_q[rd_q];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ($clog2(BUF_DEPTH))'((int'(wr_q) + 1) % BUF_DEPTH);
      end
      if (pop) begin
        rd_q <= ($clog2(BUF_DEPTH))'((int'(rd_q) + 1) % BUF_DEPTH);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + ONE_CNT;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - ONE_CNT;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (push) begin
      mem_q[wr_q] <= rx_byte.data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic take;

  assign take = req_valid && req_ready;

  a_get_id_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_GET_ID
    |=> tx_valid && tx_byte.data == 8'h14)
    else $error("identification opcode wrong");

  a_reset_codes: assert property (
    @(posedge clock) disable iff (!rstn)
    take && (req.cmd == tcd_pkg::TCD_RESET_LINK ||
    req.cmd == tcd_pkg::TCD_RESET_DEVICE) |=> tx_byte.data ==
    (($past(req.cmd) == tcd_pkg::TCD_RESET_DEVICE) ? 8'h11 : 8'h12))
    else $error("reset opcode wrong");

  a_irq_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_READ_CLEAR_IRQ
    |=> tx_byte.data == 8'h70)
    else $error("interrupt read opcode wrong");

  a_status_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_FE_STATUS
    |=> tx_byte.data == 8'h94)
    else $error("status opcode wrong");

  a_timer_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_READ_TIMER
    |=> tx_byte.data == 8'hD1)
    else $error("timer read opcode wrong");

  a_dating_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_READ_DATING
    |=> tx_byte.data == 8'hD8)
    else $error("dating read opcode wrong");

  a_hk_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_HOUSEKEEPING
    |=> tx_byte.data == 8'h40)
    else $error("housekeeping opcode wrong");

  a_filter_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_FILTER
    |=> tx_byte.data == {6'h0C, $past(req.field)})
    else $error("filter opcode wrong");

  a_single_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_SINGLE
    |=> tx_byte.data == {6'h12, $past(req.field)})
    else $error("single counter opcode wrong");

  a_linear_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_LINEAR
    |=> tx_byte.data == {6'h2D, $past(req.field)})
    else $error("linear readout opcode wrong");

  a_index_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_LOG
    |=> tx_byte.data == {6'h2C, $past(req.field)})
    else $error("chip index not in opcode");

  a_start_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_START
    |=> tx_byte.data[7:3] == 5'h0C)
    else $error("start opcode wrong");

  a_stop_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_STOP
    |=> tx_byte.data == 8'h68)
    else $error("stop opcode wrong");

  a_tel_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_POWER
    |=> tx_byte.data == {6'h20, $past(req.field)})
    else $error("telescope field not in opcode");

  a_ctrl_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_CONTROL
    |=> tx_byte.data == {6'h23, $past(req.field)})
    else $error("control opcode wrong");

  a_enable_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_ENABLE
    |=> tx_byte.data == {6'h22, $past(req.field)})
    else $error("enable opcode wrong");

  a_drive_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_DRIVE
    |=> tx_byte.data == {6'h21, $past(req.field)})
    else $error("drive opcode wrong");

  a_init_field: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_INIT_LIN
    |=> tx_byte.data == {6'h2A, $past(req.field)})
    else $error("counter init opcode wrong");

  a_config_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_FE_CONFIG
    |=> tx_byte.data == {6'h24, $past(req.field)})
    else $error("front-end config opcode wrong");

  a_page_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_MODE_PAGE
    |=> tx_byte.data[7:2] == 6'h28)
    else $error("mode and page opcode wrong");

  a_test_gen_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_TEST_GEN
    |=> tx_byte.data == 8'hE0)
    else $error("test generator opcode wrong");

  a_latch_code: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_LATCHUP
    |=> tx_byte.data[7:4] == 4'hF)
    else $error("latchup opcode wrong");

  a_timer_args: assert property (
    @(posedge clock) disable iff (!rstn)
    take && req.cmd == tcd_pkg::TCD_SET_TIMER
    |=> (tx_byte.data == 8'hD0 && busy) ##1 (busy [*3]))
    else $error("set timer must hold for three arguments");

  a_tx_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_byte.data))
    else $error("link byte changed before taken");

  a_no_drop: assert property (
    @(posedge clock) disable iff (!rstn)
    rx_valid && rx_ready
    |=> ans_valid)
    else $error("taken answer byte not offered");

  a_buf_bound: assert property (
    @(posedge clock) disable iff (!rstn)
    cnt_q <= FULL_CNT)
    else $error("buffer count beyond depth");

  a_ans_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    ans_valid && !ans_ready
    |=> ans_valid && $stable(ans_byte.data))
    else $error("answer byte changed before taken");

endmodule

// *** testbench/tcd_dev_model.sv ***
// Behavioural model of the telescope control device on the byte link.
// Assumes the host offers one byte at a time with valid and ready.
`timescale 1ns/1ps

module tcd_dev_model #(
  parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] FE_ERR = 8'h03
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bytes from the host
  input wire logic tx_valid,
  output logic tx_ready = 1'b0,
  input wire tcd_pkg::tcd_byte_t tx_byte,
  // Answer bytes
  output logic rx_valid = 1'b0,
  input wire logic rx_ready,
  output tcd_pkg::tcd_byte_t rx_byte = 8'hFF,
  // Stall control
  input wire logic slow
);
  logic [7:0] q[$];
  logic [7:0] irq_q;
  logic [7:0] op_q;
  logic [23:0] timer_q;
  logic [23:0] acc;
  int left;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      q.delete();
      irq_q <= 8'h0C;
      timer_q <= 24'h000000;
      left = 0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        if (left > 0) begin
          acc = {acc[15:0], tx_byte.data};
          left = left - 1;
          if (left == 0 && op_q == 8'hD0) timer_q <= acc;
        end else begin
          op_q <= tx_byte.data;
          casez (tx_byte.data)
            8'h14: q.push_back(ID_CODE);
            8'h11, 8'h12: q.delete();
            8'h70: begin
              q.push_back(irq_q);
              irq_q <= 8'h00;
            end
            8'h94: q.push_back(FE_ERR);
            8'hD1: begin
              q.push_back(timer_q[23:16]);
              q.push_back(timer_q[15:8]);
              q.push_back(timer_q[7:0]);
            end
            8'hD0, 8'b100100??: left = 3;
            8'b101000??, 8'hE0, 8'b1111????: left = 1;
            default: ;
          endcase
        end
      end
      // A released line shows a moving pattern, never stale data
      if (!rx_valid || rx_ready) begin
        if (q.size() > 0) begin
          rx_valid <= 1'b1;
          rx_byte.data <= q.pop_front();
        end else begin
          rx_valid <= 1'b0;
          rx_byte.data <= ~rx_byte.data;
        end
      end
    end
  end
endmodule

// *** testbench/telescope_command_decoder_tb_top.sv ***
// Self-checking bench for the telescope command host.
// Assumes tcd_pkg, tcd_host and the device model are compiled first.
`timescale 1ns/1ps

module telescope_command_decoder_tb_top;
  logic clock = 1'b0;
  logic rstn, req_valid, req_ready, tx_valid, tx_ready, rx_valid;
  logic rx_ready, ans_valid, ans_ready, busy, slow;
  tcd_pkg::tcd_req_t req;
  tcd_pkg::tcd_byte_t tx_byte, rx_byte, ans_byte;
  logic [7:0] sent[$];
  int num_errors, compares;

  always #25 clock = ~clock;

  tcd_host uut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .ans_valid(ans_valid),
    .ans_ready(ans_ready), .ans_byte(ans_byte), .busy(busy));

  tcd_dev_model dev (.clock(clock), .rstn(rstn), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .slow(slow));

  always @(posedge clock) begin
    if (tx_valid && tx_ready) sent.push_back(tx_byte.data);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Expected bytes left-aligned in e, n of them
  task xfer(input tcd_pkg::tcd_cmd_t c, input logic [1:0] f,
            input logic [23:0] a, input int n, input logic [31:0] e);
    int i;
    sent.delete();
    req.cmd = c;
    req.field = f;
    req.args = a;
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 50) begin
      @(posedge clock);
      #1;
      i++;
    end
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    chk({7'h00, req_ready}, 8'h00);
    i = 0;
    while ((busy !== 1'b0 || sent.size() < n) && i < 200) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk(8'(sent.size()), 8'(n));
    for (i = 0; i < n; i++) chk(sent[i], e[31-8*i -: 8]);
  endtask

  task ans(input logic [7:0] e);
    int i;
    i = 0;
    while (ans_valid !== 1'b1 && i < 100) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk({7'h00, ans_valid}, 8'h01);
    chk(ans_byte.data, e);
    ans_ready = 1'b1;
    @(posedge clock);
    #1;
    ans_ready = 1'b0;
    // Let an edge pass so a following call never re-raises at once
    @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_plain;
    xfer(tcd_pkg::TCD_RESET_LINK, 2'h0, 24'h0, 1, 32'h12000000);
    xfer(tcd_pkg::TCD_RESET_DEVICE, 2'h0, 24'h0, 1, 32'h11000000);
    xfer(tcd_pkg::TCD_READ_DATING, 2'h0, 24'h0, 1, 32'hD8000000);
    xfer(tcd_pkg::TCD_HOUSEKEEPING, 2'h0, 24'h0, 1, 32'h40000000);
    xfer(tcd_pkg::TCD_FILTER, 2'h2, 24'h0, 1, 32'h32000000);
    xfer(tcd_pkg::TCD_SINGLE, 2'h3, 24'h0, 1, 32'h4B000000);
    xfer(tcd_pkg::TCD_LINEAR, 2'h1, 24'h0, 1, 32'hB5000000);
    xfer(tcd_pkg::TCD_LOG, 2'h0, 24'h0, 1, 32'hB0000000);
    xfer(tcd_pkg::TCD_START, 2'h3, 24'h0, 1, 32'h63000000);
    xfer(tcd_pkg::TCD_STOP, 2'h0, 24'h0, 1, 32'h68000000);
    xfer(tcd_pkg::TCD_POWER, 2'h1, 24'h0, 1, 32'h81000000);
    xfer(tcd_pkg::TCD_CONTROL, 2'h2, 24'h0, 1, 32'h8E000000);
    xfer(tcd_pkg::TCD_ENABLE, 2'h3, 24'h0, 1, 32'h8B000000);
    xfer(tcd_pkg::TCD_DRIVE, 2'h0, 24'h0, 1, 32'h84000000);
    xfer(tcd_pkg::TCD_INIT_LIN, 2'h1, 24'h0, 1, 32'hA9000000);
  endtask

  // Link stalls every other cycle here
  task t_args;
    xfer(tcd_pkg::TCD_SET_TIMER, 2'h0, 24'hA5C3E1, 4, 32'hD0A5C3E1);
    xfer(tcd_pkg::TCD_FE_CONFIG, 2'h2, 24'h0102FE, 4,
      32'h920102FE);
    xfer(tcd_pkg::TCD_MODE_PAGE, 2'h1, 24'h00005A, 2, 32'hA15A0000);
    xfer(tcd_pkg::TCD_TEST_GEN, 2'h0, 24'h00003C, 2, 32'hE03C0000);
    xfer(tcd_pkg::TCD_LATCHUP, 2'h0, 24'h070081, 2, 32'hF7810000);
  endtask

  task t_answers;
    int i;
    xfer(tcd_pkg::TCD_GET_ID, 2'h0, 24'h0, 1, 32'h14000000);
    ans(8'h5A);
    xfer(tcd_pkg::TCD_FE_STATUS, 2'h0, 24'h0, 1, 32'h94000000);
    ans(8'h03);
    xfer(tcd_pkg::TCD_READ_CLEAR_IRQ, 2'h0, 24'h0, 1, 32'h70000000);
    ans(8'h0C);
    xfer(tcd_pkg::TCD_READ_CLEAR_IRQ, 2'h0, 24'h0, 1, 32'h70000000);
    ans(8'h00);
    // Three answer bytes against a two-entry buffer
    xfer(tcd_pkg::TCD_READ_TIMER, 2'h0, 24'h0, 1, 32'hD1000000);
    i = 0;
    while (rx_ready !== 1'b0 && i < 50) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk({7'h00, rx_ready}, 8'h00);
    ans(8'hA5);
    ans(8'hC3);
    ans(8'hE1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    ans_ready = 1'b0;
    slow = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    #1;
    chk({3'h0, req_ready, tx_valid, busy, rx_ready, ans_valid}, 8'h12);
    rstn = 1'b1;
    t_plain();
    slow = 1'b1;
    t_args();
    slow = 1'b0;
    t_answers();
    complete_run();
  end

  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule
